// file: hdl/adcr_pkg.sv
// Summary of operation
// - Results are 12-bit unsigned, high/low pair
// - Source field plus channel field pick input
// - Channel field picks one of twelve pins
// - Source field picks internal or external input
// - Five internal sources are selectable
// - Align 0: left-justified, low nibble zero
// - Align 1: right-justified, high nibble zero
// - Unused result bits read as zero
// - Disabled converter leaves results untouched
// - Analog pin drops its shared function
// - Analog pin loses its pull-high resistor
// - Read-only calibration pair, left-aligned
// - One bit enables bandgap reference output
// - Sensor enable bit0, gain enable bit1
// - Primary control: start, busy, enable, align, channel
// - Secondary control: source, reference, clock select
// - At most one analog input routed at once
package adcr_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [2:0] ADDR_RES_HI   = 3'h0;
   localparam logic [2:0] ADDR_RES_LO   = 3'h1;
   localparam logic [2:0] ADDR_CTRL_PRI = 3'h2;
   localparam logic [2:0] ADDR_CTRL_SEC = 3'h3;
   localparam logic [2:0] ADDR_TEMP     = 3'h4;
   localparam logic [2:0] ADDR_BGAP     = 3'h5;
   localparam logic [2:0] ADDR_CAL_HI   = 3'h6;
   localparam logic [2:0] ADDR_CAL_LO   = 3'h7;

   // ------------------------------------------------------------
   // Sizes, field positions and reset values
   // ------------------------------------------------------------
   localparam int         RES_W      = 12;
   localparam int         EXT_N      = 12;
   localparam int         INT_N      = 5;
   localparam int         SRC_N      = EXT_N + INT_N;
   localparam int         TEMP_EN_B  = 0;
   localparam int         TEMP_GAIN_B = 1;
   localparam int         BGAP_EN_B  = 0;
   localparam logic [7:0] RST_CTRL_PRI = 8'h00;
   localparam logic [7:0] RST_CTRL_SEC = 8'h00;
   localparam logic [1:0] RST_TEMP   = 2'h0;
   localparam logic       RST_BGAP   = 1'b0;
   localparam logic [11:0] RST_RESULT = 12'h000;

   // Input source codes; codes 6 and 7 route nothing
   localparam logic [2:0] SRC_EXT   = 3'h0;
   localparam logic [2:0] SRC_BGAP  = 3'h1;
   localparam logic [2:0] SRC_AMP0  = 3'h2;
   localparam logic [2:0] SRC_AMP1  = 3'h3;
   localparam logic [2:0] SRC_LINE  = 3'h4;
   localparam logic [2:0] SRC_TEMP  = 3'h5;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic       start;
      logic       conv_busy_flag;
      logic       converter_enable;
      logic       result_align_sel;
      logic [3:0] ext_channel_sel;
   } adcr_ctrl_pri_t;

   typedef struct packed {
      logic [2:0] input_source_sel;
      logic [1:0] ref_voltage_sel;
      logic [2:0] conv_clock_sel;
   } adcr_ctrl_sec_t;

   typedef struct packed {
      logic [2:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } adcr_bus_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_CONV  = 2'b01,
      ST_STORE = 2'b11
   } adcr_state_t;

endpackage : adcr_pkg

// file: hdl/adcr_ctrl.sv
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module adcr_ctrl
   import adcr_pkg::*;
(
   input  wire logic                 clock,            // System clock, 50 MHz
   input  wire logic                 rst_n,            // Asynchronous reset, active low
   input  wire adcr_bus_t            bus,              // Register access request
   output logic [7:0]                rdata,            // Read data, cycle after read
   input  wire logic                 core_done,        // Converter core finished
   input  wire logic [RES_W-1:0]     core_data,        // Converter core result
   output logic                      core_start,       // Start pulse to core
   output logic [SRC_N-1:0]          analog_sel,       // One-hot analog route
   output logic                      converter_enable, // Core power enable
   output logic [1:0]                ref_voltage_sel,  // Reference select
   output logic [2:0]                conv_clock_sel,   // Conversion clock select
   output logic                      temp_sensor_enable,   // Sensor enable
   output logic                      temp_amp_gain_enable, // Sensor gain enable
   output logic                      bandgap_out_enable,   // Bandgap output enable
   input  wire logic [RES_W-1:0]     cal_value,        // Stored calibration result
   input  wire logic [EXT_N-1:0]     pin_adc_sel,      // Pin-share analog selection
   input  wire logic [EXT_N-1:0]     pin_pullup_req,   // Pull-high requested per pin
   output logic [EXT_N-1:0]          pin_func_off,     // Shared function removed
   output logic [EXT_N-1:0]          pin_pullup_on     // Pull-high actually applied
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [15:0] align_word(input logic [RES_W-1:0] v,
                                              input logic right);
      if (right) begin
         align_word = {4'h0, v};
      end else begin
         align_word = {v, 4'h0};
      end
   endfunction : align_word

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   adcr_ctrl_pri_t       pri_q;
   adcr_ctrl_sec_t       sec_q;
   logic [1:0]           temp_q;
   logic                 bgap_q;
   logic [RES_W-1:0]     result_q;
   adcr_state_t          state_q;
   adcr_state_t          state_d;
   logic [RES_W-1:0]     latch_q;
   logic [7:0]           rdata_q;
   logic [SRC_N-1:0]     sel_q;
   logic                 start_q;

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   wire                  wr_pri    = bus.wr && bus.addr == ADDR_CTRL_PRI;
   wire                  wr_sec    = bus.wr && bus.addr == ADDR_CTRL_SEC;
   wire                  wr_temp   = bus.wr && bus.addr == ADDR_TEMP;
   wire                  wr_bgap   = bus.wr && bus.addr == ADDR_BGAP;
   wire adcr_ctrl_pri_t  wpri      = adcr_ctrl_pri_t'(bus.wdata);
   wire                  enabled   = pri_q.converter_enable;
   wire                  start_req = wr_pri && wpri.start && wpri.converter_enable &&
                                     state_q == ST_IDLE;
   wire [15:0]           res_word  = align_word(result_q, pri_q.result_align_sel);
   wire [15:0]           cal_word  = align_word(cal_value, 1'b0);

   // Source route: one core, so exactly one bit or none
   logic [SRC_N-1:0]     sel_d;
   always_comb begin
      sel_d = '0;
      case (sec_q.input_source_sel)
         SRC_EXT: begin
            if (pri_q.ext_channel_sel < 4'(EXT_N)) begin
               sel_d[pri_q.ext_channel_sel] = 1'b1;
            end
         end
         SRC_BGAP: begin
            sel_d[EXT_N + 0] = 1'b1;
         end
         SRC_AMP0: begin
            sel_d[EXT_N + 1] = 1'b1;
         end
         SRC_AMP1: begin
            sel_d[EXT_N + 2] = 1'b1;
         end
         SRC_LINE: begin
            sel_d[EXT_N + 3] = 1'b1;
         end
         SRC_TEMP: begin
            sel_d[EXT_N + 4] = 1'b1;
         end
         default: begin
            sel_d = '0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Conversion sequence
   // ------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (start_req) begin
               state_d = ST_CONV;
            end
         end
         ST_CONV: begin
            // Dropping the enable abandons the conversion; the result stays put
            if (!enabled) begin
               state_d = ST_IDLE;
            end else if (core_done) begin
               state_d = ST_STORE;
            end
         end
         ST_STORE: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   a_store_next: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == ST_CONV && enabled && core_done) |=> state_q == ST_STORE)
      else $error("conversion end not stored");

   a_abort_idle: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == ST_CONV && !enabled) |=> state_q == ST_IDLE && !pri_q.conv_busy_flag)
      else $error("abort did not return to idle");

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         latch_q <= RST_RESULT;
      end else if (state_q == ST_CONV && core_done) begin
         latch_q <= core_data;
      end
   end

   // Result only moves in STORE, which needs the converter on
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         result_q <= RST_RESULT;
      end else if (state_q == ST_STORE && enabled) begin
         result_q <= latch_q;
      end
   end

   a_result_store: assert property (@(posedge clock) disable iff (!rst_n)
      $changed(result_q) |-> $past(state_q) == ST_STORE)
      else $error("result moved outside store");

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         start_q <= 1'b0;
      end else begin
         start_q <= start_req;
      end
   end

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   // Busy is hardware-owned; a software write to it is ignored
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pri_q <= adcr_ctrl_pri_t'(RST_CTRL_PRI);
      end else begin
         if (wr_pri) begin
            pri_q.start            <= wpri.start;
            pri_q.converter_enable <= wpri.converter_enable;
            pri_q.result_align_sel <= wpri.result_align_sel;
            pri_q.ext_channel_sel  <= wpri.ext_channel_sel;
         end
         pri_q.conv_busy_flag <= (state_d != ST_IDLE);
      end
   end

   a_start_pulse: assert property (@(posedge clock) disable iff (!rst_n)
      core_start |=> !core_start)
      else $error("start pulse longer than one cycle");

   a_busy_refuse: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_pri && pri_q.conv_busy_flag) |=> !core_start)
      else $error("start accepted while busy");

   a_busy_hold: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == ST_CONV && enabled && !core_done) |=> pri_q.conv_busy_flag)
      else $error("busy dropped before result stored");

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sec_q  <= adcr_ctrl_sec_t'(RST_CTRL_SEC);
         temp_q <= RST_TEMP;
         bgap_q <= RST_BGAP;
      end else begin
         if (wr_sec) begin
            sec_q <= adcr_ctrl_sec_t'(bus.wdata);
         end
         if (wr_temp) begin
            temp_q <= bus.wdata[1:0];
         end
         if (wr_bgap) begin
            bgap_q <= bus.wdata[BGAP_EN_B];
         end
      end
   end

   a_sec_fields: assert property (@(posedge clock) disable iff (!rst_n)
      wr_sec |=> ref_voltage_sel == $past(bus.wdata[4:3]) &&
                 conv_clock_sel == $past(bus.wdata[2:0]))
      else $error("secondary control fields wrong");

   a_bgap_bit: assert property (@(posedge clock) disable iff (!rst_n)
      wr_bgap |=> bandgap_out_enable == $past(bus.wdata[BGAP_EN_B]))
      else $error("bandgap enable bit wrong");

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sel_q <= '0;
      end else begin
         sel_q <= sel_d;
      end
   end

   a_src_none: assert property (@(posedge clock) disable iff (!rst_n)
      (sec_q.input_source_sel > SRC_TEMP) |=> analog_sel == '0)
      else $error("unused source code routed an input");

   a_chan_none: assert property (@(posedge clock) disable iff (!rst_n)
      (sec_q.input_source_sel == SRC_EXT && pri_q.ext_channel_sel >= 4'(EXT_N))
      |=> analog_sel == '0)
      else $error("channel beyond the pins routed an input");

   a_route_bgap: assert property (@(posedge clock) disable iff (!rst_n)
      (sec_q.input_source_sel == SRC_BGAP) |=> analog_sel[EXT_N])
      else $error("bandgap source not routed");

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [7:0] rmux;
   always_comb begin
      rmux = 8'h00;
      case (bus.addr)
         ADDR_RES_HI:   rmux = res_word[15:8];
         ADDR_RES_LO:   rmux = res_word[7:0];
         ADDR_CTRL_PRI: rmux = pri_q;
         ADDR_CTRL_SEC: rmux = sec_q;
         ADDR_TEMP:     rmux = {6'h00, temp_q};
         ADDR_BGAP:     rmux = {7'h00, bgap_q};
         ADDR_CAL_HI:   rmux = cal_word[15:8];
         ADDR_CAL_LO:   rmux = cal_word[7:0];
         default:       rmux = 8'h00;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= 8'h00;
      end else if (bus.rd) begin
         rdata_q <= rmux;
      end
   end

   // Alignment applies at read time, so flipping it reformats a stored result
   a_left_high: assert property (@(posedge clock) disable iff (!rst_n)
      (bus.rd && bus.addr == ADDR_RES_HI && !pri_q.result_align_sel)
      |=> rdata == $past(result_q[11:4]))
      else $error("left aligned high byte wrong");

   a_right_low: assert property (@(posedge clock) disable iff (!rst_n)
      (bus.rd && bus.addr == ADDR_RES_LO && pri_q.result_align_sel)
      |=> rdata == $past(result_q[7:0]))
      else $error("right aligned low byte wrong");

   a_cal_high: assert property (@(posedge clock) disable iff (!rst_n)
      (bus.rd && bus.addr == ADDR_CAL_HI) |=> rdata == $past(cal_value[11:4]))
      else $error("calibration high byte wrong");

   // ------------------------------------------------------------
   // Pin sharing
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < EXT_N; g++) begin : g_pin
         assign pin_func_off[g]  = pin_adc_sel[g];
         assign pin_pullup_on[g] = pin_pullup_req[g] & ~pin_adc_sel[g];
      end
   endgenerate

   // Kept combinational so a pin gives up its other roles in the same cycle
   a_pin_func: assert property (@(posedge clock) disable iff (!rst_n)
      pin_func_off == pin_adc_sel)
      else $error("shared function kept on analog pin");

   a_pin_pullup: assert property (@(posedge clock) disable iff (!rst_n)
      (pin_pullup_on & pin_adc_sel) == '0)
      else $error("pull-high left on analog pin");

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rdata                = rdata_q;
   assign core_start           = start_q;
   assign analog_sel           = sel_q;
   assign converter_enable     = pri_q.converter_enable;
   assign ref_voltage_sel      = sec_q.ref_voltage_sel;
   assign conv_clock_sel       = sec_q.conv_clock_sel;
   assign temp_sensor_enable   = temp_q[TEMP_EN_B];
   assign temp_amp_gain_enable = temp_q[TEMP_GAIN_B];
   assign bandgap_out_enable   = bgap_q;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_result_twelve: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == ST_STORE && enabled) |=> result_q == $past(latch_q))
      else $error("result not loaded from core");

   a_align_left: assert property (@(posedge clock) disable iff (!rst_n)
      (bus.rd && bus.addr == ADDR_RES_LO && !pri_q.result_align_sel)
      |=> rdata == {$past(result_q[3:0]), 4'h0})
      else $error("left aligned low byte wrong");

   a_align_right: assert property (@(posedge clock) disable iff (!rst_n)
      (bus.rd && bus.addr == ADDR_RES_HI && pri_q.result_align_sel)
      |=> rdata == {4'h0, $past(result_q[11:8])})
      else $error("right aligned high byte wrong");

   a_disabled_hold: assert property (@(posedge clock) disable iff (!rst_n)
      !enabled |=> $stable(result_q))
      else $error("result changed while disabled");

   a_route_onehot: assert property (@(posedge clock) disable iff (!rst_n)
      $onehot0(analog_sel))
      else $error("more than one analog input routed");

   a_route_ext: assert property (@(posedge clock) disable iff (!rst_n)
      (sec_q.input_source_sel == SRC_EXT && pri_q.ext_channel_sel == 4'h5)
      |=> analog_sel[5])
      else $error("external channel not routed");

   a_pin_release: assert property (@(posedge clock) disable iff (!rst_n)
      pin_adc_sel[0] |-> !pin_pullup_on[0] && pin_func_off[0])
      else $error("analog pin kept pull-high or function");

   a_busy_clear: assert property (@(posedge clock) disable iff (!rst_n)
      (state_q == ST_STORE) |=> !pri_q.conv_busy_flag ##0 $changed(state_q))
      else $error("busy not cleared after store");

   a_start_busy: assert property (@(posedge clock) disable iff (!rst_n)
      start_req |=> core_start && pri_q.conv_busy_flag)
      else $error("start did not raise busy");

   a_cal_read: assert property (@(posedge clock) disable iff (!rst_n)
      (bus.rd && bus.addr == ADDR_CAL_LO) |=> rdata[3:0] == 4'h0)
      else $error("calibration low nibble not zero");

   a_temp_bits: assert property (@(posedge clock) disable iff (!rst_n)
      (wr_temp) |=> temp_sensor_enable == $past(bus.wdata[0]) &&
                    temp_amp_gain_enable == $past(bus.wdata[1]))
      else $error("sensor control bits wrong");

endmodule : adcr_ctrl
`default_nettype wire

// file: test/tb_adc_control_and_result_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_adc_control_and_result_regs
   import adcr_pkg::*;
;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic                 clock;
   logic                 rst_n;
   adcr_bus_t            bus;
   logic [7:0]           rdata;
   logic                 core_done;
   logic [RES_W-1:0]     core_data;
   logic                 core_start;
   logic [SRC_N-1:0]     analog_sel;
   logic                 converter_enable;
   logic [1:0]           ref_voltage_sel;
   logic [2:0]           conv_clock_sel;
   logic                 temp_sensor_enable;
   logic                 temp_amp_gain_enable;
   logic                 bandgap_out_enable;
   logic [RES_W-1:0]     cal_value;
   logic [EXT_N-1:0]     pin_adc_sel;
   logic [EXT_N-1:0]     pin_pullup_req;
   logic [EXT_N-1:0]     pin_func_off;
   logic [EXT_N-1:0]     pin_pullup_on;
   logic [7:0]           rd_v;
   int                   n_mismatch;
   int                   checks_done;

   adcr_ctrl DUT (
      .clock                (clock),
      .rst_n                (rst_n),
      .bus                  (bus),
      .rdata                (rdata),
      .core_done            (core_done),
      .core_data            (core_data),
      .core_start           (core_start),
      .analog_sel           (analog_sel),
      .converter_enable     (converter_enable),
      .ref_voltage_sel      (ref_voltage_sel),
      .conv_clock_sel       (conv_clock_sel),
      .temp_sensor_enable   (temp_sensor_enable),
      .temp_amp_gain_enable (temp_amp_gain_enable),
      .bandgap_out_enable   (bandgap_out_enable),
      .cal_value            (cal_value),
      .pin_adc_sel          (pin_adc_sel),
      .pin_pullup_req       (pin_pullup_req),
      .pin_func_off         (pin_func_off),
      .pin_pullup_on        (pin_pullup_on)
   );

   always #10 clock = ~clock;

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic end_sim;
      $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      bus.wr <= 1'b0;
   endtask : wr_reg

   // Read data appear in the cycle after the strobe and hold until the next read
   task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
      @(posedge clock);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask : rd_reg

   task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] e);
      rd_reg(a, rd_v);
      check(what, rd_v, e);
   endtask : rd_chk

   task automatic wait_idle;
      int i;
      rd_v = 8'h40;
      for (i = 0; i < 8 && rd_v[6]; i++)
         rd_reg(ADDR_CTRL_PRI, rd_v);
      check("busy_idle", rd_v[6], 32'h0);
      if (rd_v[6] !== 1'b0) begin
         end_sim();
      end
   endtask : wait_idle

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      rd_chk("ctrl_pri", ADDR_CTRL_PRI, 8'h00);
      rd_chk("ctrl_sec", ADDR_CTRL_SEC, 8'h00);
      rd_chk("temp_ctl", ADDR_TEMP, 8'h00);
      rd_chk("bgap_ctl", ADDR_BGAP, 8'h00);
      wr_reg(ADDR_CTRL_PRI, 8'h40);
      rd_chk("busy_ro", ADDR_CTRL_PRI, 8'h00);
      wr_reg(ADDR_RES_HI, 8'hff);
      rd_chk("res_hi", ADDR_RES_HI, 8'h00);
      rd_chk("res_lo", ADDR_RES_LO, 8'h00);
      check("analog_sel", analog_sel, 32'h1);
   endtask : t_reset

   task automatic t_route;
      int c;
      for (c = 0; c < 16; c++) begin
         wr_reg(ADDR_CTRL_PRI, {4'h0, c[3:0]});
         repeat (2) @(posedge clock);
         #1 check("ext route", analog_sel, c < 12 ? 32'h1 << c : 32'h0);
      end
      wr_reg(ADDR_CTRL_PRI, 8'h05);
      for (c = 1; c < 9; c++) begin
         wr_reg(ADDR_CTRL_SEC, {c[2:0], 5'h00});
         repeat (2) @(posedge clock);
         #1 check("int route", analog_sel,
                  c == 8 ? 32'h20 : c < 6 ? 32'h1 << (11 + c) : 32'h0);
      end
   endtask : t_route

   task automatic t_fields;
      wr_reg(ADDR_CTRL_SEC, 8'hb5);
      rd_chk("ctrl_sec", ADDR_CTRL_SEC, 8'hb5);
      check("ref_sel", ref_voltage_sel, 32'h2);
      check("clk_sel", conv_clock_sel, 32'h5);
      wr_reg(ADDR_CTRL_SEC, 8'h00);
      wr_reg(ADDR_TEMP, 8'h02);
      #1 check("temp pair", {temp_amp_gain_enable, temp_sensor_enable}, 32'h2);
      wr_reg(ADDR_TEMP, 8'h01);
      #1 check("temp pair", {temp_amp_gain_enable, temp_sensor_enable}, 32'h1);
      wr_reg(ADDR_BGAP, 8'h01);
      #1 check("bgap_en", bandgap_out_enable, 32'h1);
      wr_reg(ADDR_BGAP, 8'h00);
      #1 check("bgap_en", bandgap_out_enable, 32'h0);
   endtask : t_fields

   // Second start lands while busy and must be refused
   task automatic t_conv(input logic [11:0] d);
      wr_reg(ADDR_CTRL_PRI, 8'ha0);
      #1 check("core_start", core_start, 32'h1);
      check("conv_en", converter_enable, 32'h1);
      wr_reg(ADDR_CTRL_PRI, 8'ha0);
      #1 check("core_start", core_start, 32'h0);
      rd_chk("busy", ADDR_CTRL_PRI, 8'he0);
      @(posedge clock);
      core_done <= 1'b1;
      core_data <= d;
      @(posedge clock);
      core_done <= 1'b0;
      wait_idle();
      rd_chk("res_hi a0", ADDR_RES_HI, d[11:4]);
      rd_chk("res_lo a0", ADDR_RES_LO, {d[3:0], 4'h0});
      wr_reg(ADDR_CTRL_PRI, 8'h30);
      rd_chk("res_hi a1", ADDR_RES_HI, {4'h0, d[11:8]});
      rd_chk("res_lo a1", ADDR_RES_LO, d[7:0]);
   endtask : t_conv

   task automatic t_abort(input logic [11:0] prev);
      wr_reg(ADDR_CTRL_PRI, 8'ha0);
      wr_reg(ADDR_CTRL_PRI, 8'h00);
      // Core finishes in the very cycle the enable has gone
      core_done <= 1'b1;
      core_data <= 12'h111;
      @(posedge clock);
      core_done <= 1'b0;
      rd_chk("abort busy", ADDR_CTRL_PRI, 8'h00);
      rd_chk("kept hi", ADDR_RES_HI, prev[11:4]);
      rd_chk("kept lo", ADDR_RES_LO, {prev[3:0], 4'h0});
      wr_reg(ADDR_CTRL_PRI, 8'h80);
      #1 check("start off", core_start, 32'h0);
   endtask : t_abort

   task automatic t_cal;
      rd_chk("cal_hi", ADDR_CAL_HI, 8'h5a);
      rd_chk("cal_lo", ADDR_CAL_LO, 8'h30);
      wr_reg(ADDR_CAL_HI, 8'hff);
      rd_chk("cal_hi ro", ADDR_CAL_HI, 8'h5a);
   endtask : t_cal

   task automatic t_pins;
      @(posedge clock);
      pin_adc_sel    <= 12'h0f3;
      pin_pullup_req <= 12'h5a5;
      @(posedge clock);
      #1 check("func_off", pin_func_off, 32'h0f3);
      check("pullup_on", pin_pullup_on, 32'h504);
   endtask : t_pins

   // Reset in mid-run must clear control and result alike
   task automatic t_midrst;
      @(posedge clock);
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      rd_chk("rst ctrl_pri", ADDR_CTRL_PRI, 8'h00);
      rd_chk("rst temp_ctl", ADDR_TEMP, 8'h00);
      rd_chk("rst res_hi", ADDR_RES_HI, 8'h00);
   endtask : t_midrst

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      clock          = 1'b0;
      rst_n          = 1'b0;
      bus            = '0;
      core_done      = 1'b0;
      core_data      = '0;
      cal_value      = 12'h5a3;
      pin_adc_sel    = '0;
      pin_pullup_req = '0;
      n_mismatch     = 0;
      checks_done    = 0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_reset();
      t_route();
      t_fields();
      t_conv(12'hc5a);
      t_conv(12'h3e7);
      t_abort(12'h3e7);
      t_midrst();
      t_cal();
      t_pins();
      end_sim();
   end

endmodule : tb_adc_control_and_result_regs
`default_nettype wire
